// ==== rtl/bseq_pkg.sv ====
// Package of register map, field layout, reset values and timing for the burst sequencer.
package bseq_pkg;
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_FREQ   = 8'h04;
    localparam logic [7:0] OFF_PHASE  = 8'h08;
    localparam logic [7:0] OFF_CYCLES = 8'h0c;
    localparam logic [7:0] OFF_PERIOD = 8'h10;
    localparam logic [7:0] OFF_COUNT  = 8'h14;
    localparam logic [7:0] OFF_DELAY  = 8'h18;
    localparam logic [7:0] OFF_MANUAL = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;

    localparam int CTRL_EN        = 0;
    localparam int CTRL_GATED     = 1;
    localparam int CTRL_SRC       = 2;
    localparam int CTRL_EDGE_FALL = 4;
    localparam int CTRL_POL_POS   = 5;
    localparam int CTRL_TOUT      = 6;
    localparam int CTRL_HOLD      = 8;
    localparam int CTRL_INF       = 10;
    localparam int CTRL_W         = 11;

    localparam logic [1:0] SRC_INT    = 2'h0;
    localparam logic [1:0] SRC_EXT    = 2'h1;
    localparam logic [1:0] SRC_MAN    = 2'h2;
    localparam logic [1:0] TOUT_UP    = 2'h1;
    localparam logic [1:0] TOUT_DOWN  = 2'h2;
    localparam logic [1:0] HOLD_START = 2'h0;

    localparam logic [10:0] CTRL_RST   = 11'h020;
    localparam logic [15:0] FREQ_RST   = 16'h0100;
    localparam logic [15:0] PHASE_RST  = 16'h0000;
    localparam logic [15:0] CYCLES_RST = 16'h0001;
    localparam logic [31:0] PERIOD_RST = 32'h0000_1000;
    localparam logic [15:0] COUNT_RST  = 16'h0001;
    localparam logic [31:0] DELAY_RST  = 32'h0000_0000;

    localparam int CLK_PERIOD_NS  = 25;
    localparam int MIN_DELAY_NS   = 75;
    localparam int TRIG_PULSE_NS  = 100;
    localparam logic [31:0] MIN_DELAY_CYC =
        32'((MIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] TRIG_PULSE_CYC =
        4'((TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_BURST, ST_GAP} bseq_state_t;
endpackage

// ==== rtl/bseq_burst_sequencer.sv ====
// Burst sequencer with APB registers that gates a phase-accumulator carrier.
// Behaviour
// - Counted-cycle burst emits exactly the programmed whole carrier cycles, then stops.
// - Gated burst passes carrier only while gate is active at chosen polarity.
// - Cycle count acts only in counted type; polarity only in gated type.
// - Internal source restarts burst trains repeatedly from an internal timer.
// - Burst period is the interval between successive burst train starts.
// - External source starts a burst on each trigger edge detected while the sequencer is idle.
// - A setting selects rising or falling external edge as trigger.
// - Each manual trigger request made while idle starts exactly one burst sequence; requests while busy are dropped.
// - Infinite cycle count keeps the carrier running after the trigger.
// - Every burst begins at the programmed start phase.
// - Programmed delay separates trigger from burst head, never below hardware latency.
// - Internal or manual source gives trigger output off, rising or falling aligned.
// - After a burst the output holds start value, end value or offset.
module bseq_burst_sequencer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_trig_in,
    output logic             carrier_on,
    output logic      [15:0] carrier_phase,
    output logic      [1:0]  hold_mode,
    output logic             trig_out,
    output logic             busy
);
    logic [10:0]             ctrl_q;
    logic [15:0]             freq_q;
    logic [15:0]             phase_start_q;
    logic [15:0]             cycles_q;
    logic [31:0]             period_q;
    logic [15:0]             count_q;
    logic [31:0]             delay_q;
    logic                    manual_q;
    logic [31:0]             prdata_q;
    logic                    pready_q;
    logic                    pslverr_q;
    logic                    ext_s1_q;
    logic                    ext_s2_q;
    logic                    ext_s3_q;
    logic                    ext_lvl_q;
    logic                    ext_prev_q;
    bseq_pkg::bseq_state_t   state_q;
    logic [31:0]             dly_cnt_q;
    logic [31:0]             per_cnt_q;
    logic [15:0]             cyc_cnt_q;
    logic [15:0]             trains_q;
    logic [15:0]             phase_q;
    logic                    carrier_on_q;
    logic [3:0]              tout_cnt_q;
    logic                    trig_out_q;

    logic                    enable;
    logic                    counted_cycle_burst;
    logic [1:0]              src;
    logic                    run;
    logic                    gate_act;
    logic                    ext_edge;
    logic                    trig_req;
    logic                    burst_start;
    logic                    burst_end;
    logic                    wrap;
    logic [16:0]             phase_sum;
    logic [16:0]             cyc_next;
    logic                    wr_en;
    logic                    setup;
    logic [31:0]             rd_mux;
    logic                    rd_hit;

    assign enable              = ctrl_q[bseq_pkg::CTRL_EN];
    assign counted_cycle_burst = ~ctrl_q[bseq_pkg::CTRL_GATED];
    assign src                 = ctrl_q[bseq_pkg::CTRL_SRC +: 2];
    assign run                 = enable & counted_cycle_burst;
    assign setup               = psel & ~penable;
    assign wr_en               = psel & penable & pready_q & pwrite;

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave. The read word is latched in the setup cycle so prdata is a flop.
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            bseq_pkg::OFF_CTRL:   rd_mux = {21'h000000, ctrl_q};
            bseq_pkg::OFF_FREQ:   rd_mux = {16'h0000, freq_q};
            bseq_pkg::OFF_PHASE:  rd_mux = {16'h0000, phase_start_q};
            bseq_pkg::OFF_CYCLES: rd_mux = {16'h0000, cycles_q};
            bseq_pkg::OFF_PERIOD: rd_mux = period_q;
            bseq_pkg::OFF_COUNT:  rd_mux = {16'h0000, count_q};
            bseq_pkg::OFF_DELAY:  rd_mux = delay_q;
            bseq_pkg::OFF_MANUAL: rd_mux = 32'h0000_0000;
            bseq_pkg::OFF_STATUS: rd_mux = {13'h0000, state_q, carrier_on_q, trains_q};
            default:              rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~rd_hit;
            if (setup) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q        <= bseq_pkg::CTRL_RST;
            freq_q        <= bseq_pkg::FREQ_RST;
            phase_start_q <= bseq_pkg::PHASE_RST;
            cycles_q      <= bseq_pkg::CYCLES_RST;
            period_q      <= bseq_pkg::PERIOD_RST;
            count_q       <= bseq_pkg::COUNT_RST;
            delay_q       <= bseq_pkg::DELAY_RST;
            manual_q      <= 1'b0;
        end else begin
            manual_q <= wr_en && paddr == bseq_pkg::OFF_MANUAL && pwdata[0];
            if (wr_en) begin
                case (paddr)
                    bseq_pkg::OFF_CTRL:   ctrl_q        <= pwdata[bseq_pkg::CTRL_W-1:0];
                    bseq_pkg::OFF_FREQ:   freq_q        <= pwdata[15:0];
                    bseq_pkg::OFF_PHASE:  phase_start_q <= pwdata[15:0];
                    bseq_pkg::OFF_CYCLES: cycles_q      <= pwdata[15:0];
                    bseq_pkg::OFF_PERIOD: period_q      <= pwdata;
                    bseq_pkg::OFF_COUNT:  count_q       <= pwdata[15:0];
                    bseq_pkg::OFF_DELAY:  delay_q       <= pwdata;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // External trigger or gate: three-stage synchroniser, level accepted when stages 2 and 3 agree.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_q   <= 1'b0;
            ext_s2_q   <= 1'b0;
            ext_s3_q   <= 1'b0;
            ext_lvl_q  <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_s1_q   <= ext_trig_in;
            ext_s2_q   <= ext_s1_q;
            ext_s3_q   <= ext_s2_q;
            ext_prev_q <= ext_lvl_q;
            if (ext_s2_q == ext_s3_q) begin
                ext_lvl_q <= ext_s3_q;
            end
        end
    end

    assign ext_edge = ctrl_q[bseq_pkg::CTRL_EDGE_FALL] ? (ext_prev_q & ~ext_lvl_q)
                                                       : (ext_lvl_q & ~ext_prev_q);
    assign gate_act = ctrl_q[bseq_pkg::CTRL_POL_POS] ? ext_lvl_q : ~ext_lvl_q;

    always_comb begin
        case (src)
            bseq_pkg::SRC_INT: trig_req = 1'b1;
            bseq_pkg::SRC_EXT: trig_req = ext_edge;
            bseq_pkg::SRC_MAN: trig_req = manual_q;
            default:           trig_req = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    assign phase_sum = {1'b0, phase_q} + {1'b0, freq_q};
    assign wrap      = carrier_on_q & phase_sum[16];
    assign cyc_next  = {1'b0, cyc_cnt_q} + 17'h00001;
    assign burst_start = run && ((state_q == bseq_pkg::ST_DELAY && dly_cnt_q == 32'h1)
                              || (state_q == bseq_pkg::ST_GAP && per_cnt_q == 32'h0));
    assign burst_end = run && state_q == bseq_pkg::ST_BURST && wrap
                       && !ctrl_q[bseq_pkg::CTRL_INF] && cyc_next >= {1'b0, cycles_q};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= bseq_pkg::ST_IDLE;
            dly_cnt_q <= 32'h0000_0000;
            per_cnt_q <= 32'h0000_0000;
            cyc_cnt_q <= 16'h0000;
            trains_q  <= 16'h0000;
        end else if (!run) begin
            state_q <= bseq_pkg::ST_IDLE;
        end else begin
            if (per_cnt_q != 32'h0) begin
                per_cnt_q <= per_cnt_q - 32'h1;
            end
            if (burst_start) begin
                per_cnt_q <= (period_q > 32'h1) ? period_q - 32'h1 : 32'h0;
                cyc_cnt_q <= 16'h0000;
            end else if (wrap) begin
                cyc_cnt_q <= cyc_next[15:0];
            end
            case (state_q)
                bseq_pkg::ST_IDLE: if (trig_req) begin
                    state_q <= bseq_pkg::ST_DELAY;
                    dly_cnt_q <= (delay_q > bseq_pkg::MIN_DELAY_CYC) ? delay_q
                                                                     : bseq_pkg::MIN_DELAY_CYC;
                    trains_q <= (count_q == 16'h0) ? 16'h0001 : count_q;
                end
                bseq_pkg::ST_DELAY: begin
                    dly_cnt_q <= dly_cnt_q - 32'h1;
                    if (burst_start) begin
                        state_q <= bseq_pkg::ST_BURST;
                    end
                end
                bseq_pkg::ST_BURST: if (burst_end) begin
                    if (src == bseq_pkg::SRC_INT || trains_q > 16'h1) begin
                        state_q  <= bseq_pkg::ST_GAP;
                        trains_q <= (src == bseq_pkg::SRC_INT) ? trains_q : trains_q - 16'h1;
                    end else begin
                        state_q  <= bseq_pkg::ST_IDLE;
                        trains_q <= 16'h0000;
                    end
                end
                bseq_pkg::ST_GAP: if (burst_start) begin
                    state_q <= bseq_pkg::ST_BURST;
                end
                default: state_q <= bseq_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Carrier gate and phase accumulator.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carrier_on_q <= 1'b0;
            phase_q      <= bseq_pkg::PHASE_RST;
        end else begin
            if (!enable) begin
                carrier_on_q <= 1'b0;
            end else if (!counted_cycle_burst) begin
                carrier_on_q <= gate_act;
            end else if (burst_start) begin
                carrier_on_q <= 1'b1;
            end else if (burst_end) begin
                carrier_on_q <= 1'b0;
            end
            if ((burst_start) || (enable && !counted_cycle_burst && gate_act && !carrier_on_q)) begin
                phase_q <= phase_start_q;
            end else if (burst_end && ctrl_q[bseq_pkg::CTRL_HOLD +: 2] == bseq_pkg::HOLD_START) begin
                phase_q <= phase_start_q;
            end else if (carrier_on_q) begin
                phase_q <= phase_sum[15:0];
            end
        end
    end

    // trigger output
    // Ext source disables the output because the edge already comes from outside.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tout_cnt_q <= 4'h0;
            trig_out_q <= 1'b0;
        end else begin
            if (burst_start) begin
                tout_cnt_q <= bseq_pkg::TRIG_PULSE_CYC;
            end else if (tout_cnt_q != 4'h0) begin
                tout_cnt_q <= tout_cnt_q - 4'h1;
            end
            if (src == bseq_pkg::SRC_EXT || !run) begin
                trig_out_q <= 1'b0;
            end else if (ctrl_q[bseq_pkg::CTRL_TOUT +: 2] == bseq_pkg::TOUT_UP) begin
                trig_out_q <= burst_start | (tout_cnt_q > 4'h1);
            end else if (ctrl_q[bseq_pkg::CTRL_TOUT +: 2] == bseq_pkg::TOUT_DOWN) begin
                trig_out_q <= ~(burst_start | (tout_cnt_q > 4'h1));
            end else begin
                trig_out_q <= 1'b0;
            end
        end
    end

    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign carrier_on    = carrier_on_q;
    assign carrier_phase = phase_q;
    assign hold_mode     = ctrl_q[bseq_pkg::CTRL_HOLD +: 2];
    assign trig_out      = trig_out_q;
    assign busy          = (state_q != bseq_pkg::ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_start;
        burst_start ##1 carrier_on_q;
    endsequence

    a_burst_end_stop: assert property (burst_end |=> !carrier_on_q)
        else $error("carrier still on after last cycle");
    a_gate_follows: assert property (($past(enable) && enable && !counted_cycle_burst
        && $past(!counted_cycle_burst)) |-> carrier_on_q == $past(gate_act))
        else $error("gated carrier does not follow gate");
    a_gated_no_seq: assert property (!counted_cycle_burst |=> !busy)
        else $error("sequencer runs in gated type");
    a_int_self: assert property ((run && src == bseq_pkg::SRC_INT && !busy)
        |=> state_q == bseq_pkg::ST_DELAY)
        else $error("internal source did not start");
    a_period_gap: assert property ((state_q == bseq_pkg::ST_GAP && per_cnt_q == 32'h0 && run)
        |-> s_start)
        else $error("next train not started at period");
    a_ext_edge: assert property ((run && src == bseq_pkg::SRC_EXT && !busy && ext_edge)
        |=> state_q == bseq_pkg::ST_DELAY)
        else $error("external edge ignored");
    a_man_start: assert property ((run && src == bseq_pkg::SRC_MAN && !busy && manual_q)
        |=> state_q == bseq_pkg::ST_DELAY)
        else $error("manual trigger ignored");
    a_inf_runs: assert property ((run && ctrl_q[bseq_pkg::CTRL_INF] && carrier_on_q
        && $past(run)) |=> carrier_on_q)
        else $error("infinite burst stopped");
    a_start_phase: assert property (burst_start |=> phase_q == $past(phase_start_q))
        else $error("burst not at start phase");
    a_delay_min: assert property ($rose(state_q == bseq_pkg::ST_DELAY)
        |-> (state_q == bseq_pkg::ST_DELAY)[*3])
        else $error("trigger delay below latency");
    a_trig_up: assert property ((burst_start && src != bseq_pkg::SRC_EXT
        && ctrl_q[bseq_pkg::CTRL_TOUT +: 2] == bseq_pkg::TOUT_UP) |=> trig_out_q [*4])
        else $error("trigger output pulse wrong");
    a_no_retrig: assert property ((state_q == bseq_pkg::ST_BURST || state_q == bseq_pkg::ST_GAP)
        |=> state_q != bseq_pkg::ST_DELAY)
        else $error("trigger accepted while busy");
endmodule // bseq_burst_sequencer

// ==== testbench/bseq_trig_source.sv ====
// External trigger and gate source model that drives the trigger pin of the burst sequencer.
module bseq_trig_source (
    input  wire logic pclk,
    output logic      trig_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial trig_pin = 1'b0;

    // Levels change just after a clock edge, as a synchronous source would.
    task automatic level(input logic l);
        @(posedge pclk);
        trig_pin <= l;
    endtask

    // Active phase then an equal idle phase, so the pin filter never sees a glitch.
    task automatic pulse(input logic l, input int w);
        level(l);
        repeat (w) @(posedge pclk);
        trig_pin <= ~l;
        repeat (w) @(posedge pclk);
    endtask
endmodule // bseq_trig_source

// ==== testbench/test_burst_sequencer.sv ====
// Self-checking bench for the burst sequencer: registers, triggers and burst timing.
module test_burst_sequencer;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [31:0] data; logic err; logic rd;} bseq_apb_note_t;
    typedef struct {logic [15:0] phase; logic trig; int len;} bseq_burst_note_t;

    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rv;
    logic             ext_trig_in, carrier_on, trig_out, busy;
    logic [15:0]      carrier_phase;
    logic [1:0]       hold_mode;
    bseq_apb_note_t   apb_q[$];
    bseq_burst_note_t burst_q[$];
    int               rise_t[$];
    int               dly[3] = '{3, 20, 0};
    int               bad_count = 0, num_checks = 0, cyc = 0, run = 0, seed, t0, lat;
    logic             was_on = 1'b0;

    bseq_burst_sequencer DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_trig_in(ext_trig_in), .carrier_on(carrier_on),
        .carrier_phase(carrier_phase), .hold_mode(hold_mode), .trig_out(trig_out), .busy(busy));
    bseq_trig_source src (.pclk(pclk), .trig_pin(ext_trig_in));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk) cyc <= cyc + 1;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", bad_count, num_checks);
        if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #1000000;
        bad_count++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The monitor takes the oldest note whenever an access answers or a burst starts or ends.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            check("pslverr", apb_q[0].err, 32'(pslverr));
            if (apb_q[0].rd) check("prdata", apb_q[0].data, prdata);
            void'(apb_q.pop_front());
        end
        if (carrier_on === 1'b1 && !was_on) begin
            rise_t.push_back(cyc);
            run = 0;
            if (burst_q.size() == 0) check("unexpected burst", 32'h0, 32'h1);
            else begin
                check("start phase", 32'(burst_q[0].phase), 32'(carrier_phase));
                check("trig_out", 32'(burst_q[0].trig), 32'(trig_out));
            end
        end
        if (carrier_on === 1'b1) run++;
        if (carrier_on !== 1'b1 && was_on && burst_q.size() > 0) begin
            if (burst_q[0].len > 0) check("burst length", burst_q[0].len, run);
            void'(burst_q.pop_front());
        end
        was_on = (carrier_on === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The request is held until the edge that samples pready high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        apb_q.push_back('{exp, err, !w});
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask

    task automatic wait_done();
        int k = 0;
        while (burst_q.size() > 0 && k < 5000) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 5000) check("burst wait", 32'h0, 32'h1);
    endtask

    function automatic logic [31:0] ctrl(input logic g, input logic [1:0] s, input logic f,
        input logic p, input logic [1:0] t, input logic [1:0] h, input logic inf);
        ctrl = {21'h0, inf, h, t, p, f, s, g, 1'b1};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 78573;
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(bseq_pkg::OFF_CTRL, 32'(bseq_pkg::CTRL_RST));
        rd(bseq_pkg::OFF_FREQ, 32'(bseq_pkg::FREQ_RST));
        rd(bseq_pkg::OFF_CYCLES, 32'(bseq_pkg::CYCLES_RST));
        rd(bseq_pkg::OFF_PERIOD, bseq_pkg::PERIOD_RST);
        rd(bseq_pkg::OFF_COUNT, 32'(bseq_pkg::COUNT_RST));
        rd(bseq_pkg::OFF_DELAY, bseq_pkg::DELAY_RST);
        rv = $random(seed);
        apb(1'b1, 8'h24, rv, 32'h0, 1'b1);
        apb(1'b0, 8'h24, 32'h0, 32'h0, 1'b1);
        wr(bseq_pkg::OFF_FREQ, 32'h0000_1000);
        wr(bseq_pkg::OFF_PERIOD, 32'd50);
        // Internal timer: three bursts of one carrier cycle, fifty cycles apart.
        repeat (3) burst_q.push_back('{16'h0, 1'b0, 16});
        wr(bseq_pkg::OFF_CTRL, ctrl(0, bseq_pkg::SRC_INT, 0, 0, bseq_pkg::TOUT_DOWN, 2'h1, 0));
        #1 check("hold_mode", 32'h1, 32'(hold_mode));
        wait_done();
        wr(bseq_pkg::OFF_CTRL, 32'h0);
        check("period", 32'd50, 32'(rise_t[1] - rise_t[0]));
        check("period", 32'd50, 32'(rise_t[2] - rise_t[1]));
        // Manual trigger: three trains per request, a second request mid-train is dropped.
        wr(bseq_pkg::OFF_CYCLES, 32'd2);
        wr(bseq_pkg::OFF_COUNT, 32'd3);
        wr(bseq_pkg::OFF_PERIOD, 32'd80);
        wr(bseq_pkg::OFF_CTRL, ctrl(0, bseq_pkg::SRC_MAN, 0, 0, bseq_pkg::TOUT_UP, 2'h2, 0));
        foreach (dly[i]) begin
            wr(bseq_pkg::OFF_DELAY, 32'(dly[i]));
            rise_t.delete();
            repeat (3) burst_q.push_back('{16'h0, 1'b1, 32});
            wr(bseq_pkg::OFF_MANUAL, 32'h1);
            t0 = cyc;
            while (rise_t.size() == 0 && cyc < t0 + 200) @(posedge pclk);
            wr(bseq_pkg::OFF_MANUAL, 32'h1);
            check("busy", 32'h1, 32'(busy));
            wait_done();
            check("busy", 32'h0, 32'(busy));
            // One cycle from the latched request to the delay state, one for the monitor's edge.
            lat = int'(bseq_pkg::MIN_DELAY_CYC);
            if (dly[i] > lat) lat = dly[i];
            check("delay", 32'(lat + 2), 32'(rise_t[0] - t0));
            check("spacing", 32'd80, 32'(rise_t[1] - rise_t[0]));
            check("spacing", 32'd80, 32'(rise_t[2] - rise_t[1]));
        end
        rd(bseq_pkg::OFF_MANUAL, 32'h0);
        #1 check("hold_mode", 32'h2, 32'(hold_mode));
        // External edges: the second pulse lands inside the running burst.
        wr(bseq_pkg::OFF_CYCLES, 32'd4);
        wr(bseq_pkg::OFF_COUNT, 32'd1);
        for (int f = 0; f < 2; f++) begin
            wr(bseq_pkg::OFF_CTRL, ctrl(0, bseq_pkg::SRC_EXT, f[0], 0, bseq_pkg::TOUT_UP, 0, 0));
            rise_t.delete();
            burst_q.push_back('{16'h0, 1'b0, 64});
            src.pulse(1'b1, 20);
            t0 = cyc - 20;
            src.pulse(1'b1, 20);
            wait_done();
            check("edge", 32'(f == 0), 32'(rise_t[0] < t0));
        end
        // Gating at both polarities, with a random start phase and the cycle count ignored.
        wr(bseq_pkg::OFF_PHASE, rv);
        rd(bseq_pkg::OFF_PHASE, {16'h0, rv[15:0]});
        for (int p = 1; p >= 0; p--) begin
            src.level(!p[0]);
            // Let the pin filter settle first, or a stale level opens the gate for one cycle.
            repeat (5) @(posedge pclk);
            wr(bseq_pkg::OFF_CTRL, ctrl(1, bseq_pkg::SRC_EXT, 0, p[0], 2'h0, 2'h0, 0));
            burst_q.push_back('{rv[15:0], 1'b0, 40});
            src.pulse(p[0], 40);
            wait_done();
            wr(bseq_pkg::OFF_CTRL, 32'h0);
        end
        src.level(1'b0);
        // Infinite count keeps the carrier running long past one cycle.
        wr(bseq_pkg::OFF_PHASE, 32'h0);
        wr(bseq_pkg::OFF_CTRL, ctrl(0, bseq_pkg::SRC_MAN, 0, 0, 2'h0, 2'h0, 1));
        burst_q.push_back('{16'h0, 1'b0, 0});
        wr(bseq_pkg::OFF_MANUAL, 32'h1);
        repeat (300) @(posedge pclk);
        check("infinite", 32'h1, 32'(carrier_on));
        wr(bseq_pkg::OFF_CTRL, 32'h0);
        wait_done();
        complete_run();
    end
endmodule // test_burst_sequencer
